/* File: hw/device_control_regs.sv */
// Purpose: Device control and captured slot power register bank of a switch port.
// Assumes: One clock, synchronous active-high reset, single-cycle register port.
// Notes:   Read data stands in the cycle after the read strobe only.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/10ps
module device_control_regs #(
   parameter bit UPSTREAM = 1'b1
) (
   input  wire logic                        sys_clk_i,
   input  wire logic                        rst_i,
   input  wire devctl_pkg::reg_req_type     req_i,
   input  wire devctl_pkg::power_msg_type   power_msg_i,
   input  wire devctl_pkg::error_event_type error_i,
   input  wire logic                        seq_tag_i,
   input  wire logic                        tag_step_i,
   output logic [31:0]                      rdata_o,
   output logic                             irq_o,
   output logic [3:0]                       report_enable_o,
   output logic [3:0]                       error_message_o,
   output logic [11:0]                      max_payload_bytes_o,
   output logic [11:0]                      own_read_max_o,
   output logic                             own_relaxed_order_o,
   output logic                             own_no_snoop_o,
   output logic [7:0]                       next_tag_o
);

   // Whole state of the bank.
   typedef struct packed {
      logic [31:0]                      rdata;
      logic [7:0]                       cap_value;
      logic [1:0]                       cap_scale;
      logic [15:0]                      ctl;
      logic [3:0]                       err_flags;
      logic [devctl_pkg::IRQ_WIDTH-1:0] irq_status;
      logic [devctl_pkg::IRQ_WIDTH-1:0] irq_mask;
      logic                             irq;
      logic [3:0]                       err_msg;
      logic [11:0]                      payload;
      logic [7:0]                       tag;
   } state_type;

   state_type s_q;
   state_type s_d;

   // Maps the payload code to bytes; reserved codes fall back to 128.
   function automatic logic [11:0] payload_bytes(input logic [2:0] code);
      case (code)
         3'h0:    payload_bytes = devctl_pkg::PAYLOAD_128;
         3'h1:    payload_bytes = devctl_pkg::PAYLOAD_256;
         3'h2:    payload_bytes = devctl_pkg::PAYLOAD_512;
         3'h3:    payload_bytes = devctl_pkg::PAYLOAD_1024;
         3'h4:    payload_bytes = devctl_pkg::PAYLOAD_2048;
         default: payload_bytes = devctl_pkg::PAYLOAD_128; // [R7]
      endcase
   endfunction

   // Next-state logic for registers, flags and derived outputs.
   always_comb begin
      logic [4:0] events;
      logic [7:0] tag_max;
      events = 5'h00;
      tag_max = 8'h00;
      s_d = s_q;
      s_d.rdata = 32'h0000_0000;

      // Captured slot power limit; downstream ports never update it.
      if (UPSTREAM && power_msg_i.valid) begin
         s_d.cap_value = power_msg_i.value; // [R1]
         s_d.cap_scale = power_msg_i.scale; // [R2]
      end
      if (!UPSTREAM) begin
         s_d.cap_value = 8'h00; // [R3]
         s_d.cap_scale = 2'h0;  // [R3]
      end

      // Error flags log regardless of enables; enables gate only messages.
      s_d.err_flags = s_q.err_flags | error_i; // [R13]
      s_d.err_msg = error_i & s_q.ctl[3:0];     // [R4]

      // Software write; only writable control bits change.
      if (req_i.wr) begin
         if (req_i.addr == devctl_pkg::DEV_CTL_ADDR) begin
            s_d.ctl = req_i.wdata[15:0] & devctl_pkg::CTL_WRITE_MASK; // [R14] [R5] [R9]
         end else if (req_i.addr == devctl_pkg::DEV_STS_ADDR) begin
            s_d.err_flags = (s_q.err_flags & ~req_i.wdata[3:0]) | error_i; // [R13]
         end else if (req_i.addr == devctl_pkg::IRQ_MASK_ADDR) begin
            s_d.irq_mask = req_i.wdata[devctl_pkg::IRQ_WIDTH-1:0];
         end
      end

      // Interrupt events: power message capture and each error class.
      events[devctl_pkg::IRQ_POWER_MSG] = UPSTREAM && power_msg_i.valid;
      events[devctl_pkg::IRQ_CORR]      = error_i.correctable;
      events[devctl_pkg::IRQ_NONFATAL]  = error_i.nonfatal;
      events[devctl_pkg::IRQ_FATAL]     = error_i.fatal;
      events[devctl_pkg::IRQ_UNSUP]     = error_i.unsupported;

      // Register reads; fixed bits read as zero, interrupt status clears on read.
      if (req_i.rd) begin
         if (req_i.addr == devctl_pkg::DEV_CAP_ADDR) begin
            s_d.rdata[devctl_pkg::CAP_VALUE_LSB +: 8] = s_q.cap_value; // [R1]
            s_d.rdata[devctl_pkg::CAP_SCALE_LSB +: 2] = s_q.cap_scale; // [R2]
         end else if (req_i.addr == devctl_pkg::DEV_CTL_ADDR) begin
            s_d.rdata[15:0] = s_q.ctl; // [R10] [R11] [R12]
         end else if (req_i.addr == devctl_pkg::DEV_STS_ADDR) begin
            s_d.rdata[3:0] = s_q.err_flags;
         end else if (req_i.addr == devctl_pkg::IRQ_STATUS_ADDR) begin
            s_d.rdata[devctl_pkg::IRQ_WIDTH-1:0] = s_q.irq_status;
            s_d.irq_status = '0;
         end else if (req_i.addr == devctl_pkg::IRQ_MASK_ADDR) begin
            s_d.rdata[devctl_pkg::IRQ_WIDTH-1:0] = s_q.irq_mask;
         end else if (req_i.addr == devctl_pkg::DEBUG_CTL_ADDR) begin
            s_d.rdata[0] = seq_tag_i;
         end
      end
      // A new event wins over the clear-on-read.
      s_d.irq_status = s_d.irq_status | events;
      s_d.irq = |(s_d.irq_status & s_d.irq_mask);

      // Effective payload limit from the selected code.
      s_d.payload = payload_bytes(s_d.ctl[devctl_pkg::CTL_MPS_LSB +: 3]); // [R6] [R7]

      // Debug sequential tag generator; span set by the extended tag bit.
      tag_max = s_q.ctl[devctl_pkg::CTL_ETAG_BIT] ? devctl_pkg::TAG_MAX_LONG
                                                    : devctl_pkg::TAG_MAX_SHORT; // [R8]
      if (!seq_tag_i) begin
         s_d.tag = 8'h00;
      end else if (tag_step_i) begin
         s_d.tag = (s_q.tag >= tag_max) ? 8'h00 : s_q.tag + 8'h01; // [R8]
      end
   end

   // State register with synchronous reset.
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.ctl <= devctl_pkg::CTL_RESET;
         s_q.payload <= devctl_pkg::PAYLOAD_128;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register or constant.
   assign rdata_o             = s_q.rdata;
   assign irq_o               = s_q.irq;
   assign report_enable_o     = s_q.ctl[3:0];
   assign error_message_o     = s_q.err_msg;
   assign max_payload_bytes_o = s_q.payload;
   assign own_read_max_o      = devctl_pkg::OWN_READ_MAX; // [R12]
   assign own_relaxed_order_o = 1'b0; // [R5]
   assign own_no_snoop_o      = 1'b0; // [R11]
   assign next_tag_o          = s_q.tag;

endmodule

/* File: shared/devctl_pkg.sv */
// Purpose: Constants and carrier types for the device control register bank.
// Assumes: 32-bit register port, byte addresses; control and status sit two bytes apart in one word.
// Notes:   Contract
// Contract
// R1: Upstream port latches 8-bit power limit value into capability bits 25:18.
// R2: Upstream port latches power limit scale into bits 27:26, codes 0..3.
// R3: Downstream ports keep both captured power limit fields at zero always.
// R4: Control bits 0..3 are read-write error reporting enables, reset zero.
// R5: Relaxed ordering enable bit 4 reads zero; never set in own requests.
// R6: Bits 7:5 select max payload 128..2048 bytes, read-write, reset zero.
// R7: Reserved payload codes 5..7 behave as 128-byte maximum payload.
// R8: Extended tag bit 8 read-write; with sequential tagging, tag span 31 or 255.
// R9: Phantom function enable bit 9 is hardwired to zero.
// R10: Aux power PM enable bit 10 is read-only zero.
// R11: No-snoop enable bit 11 reads zero; own requests never set, forwarded unchanged.
// R12: Max read request bits 14:12 read zero; own requests at most 128 bytes.
// R13: Errors are recorded in status flags regardless of reporting enables.
// R14: Writes to read-only or reserved bits are ignored; fixed values read back.
package devctl_pkg;

   // Register byte addresses.
   localparam logic [11:0] DEV_CAP_ADDR     = 12'h044;
   localparam logic [11:0] DEV_CTL_ADDR     = 12'h048;
   localparam logic [11:0] DEV_STS_ADDR     = 12'h04A;
   localparam logic [11:0] IRQ_STATUS_ADDR  = 12'h050;
   localparam logic [11:0] IRQ_MASK_ADDR    = 12'h054;
   localparam logic [11:0] DEBUG_CTL_ADDR   = 12'h058;

   // Capability field positions.
   localparam int CAP_VALUE_LSB  = 18;
   localparam int CAP_SCALE_LSB  = 26;

   // Control field positions.
   localparam int CTL_MPS_LSB    = 5;
   localparam int CTL_ETAG_BIT   = 8;

   // Control bits that software may change (bits 0..3, 7:5, 8).
   localparam logic [15:0] CTL_WRITE_MASK = 16'h01EF;
   localparam logic [15:0] CTL_RESET      = 16'h0000;

   // Payload sizes in bytes.
   localparam logic [11:0] PAYLOAD_128  = 12'h080;
   localparam logic [11:0] PAYLOAD_256  = 12'h100;
   localparam logic [11:0] PAYLOAD_512  = 12'h200;
   localparam logic [11:0] PAYLOAD_1024 = 12'h400;
   localparam logic [11:0] PAYLOAD_2048 = 12'h800;

   // Tag spans under sequential tagging.
   localparam logic [7:0] TAG_MAX_SHORT = 8'h1F;
   localparam logic [7:0] TAG_MAX_LONG  = 8'hFF;

   // Largest own read request in bytes.
   localparam logic [11:0] OWN_READ_MAX = 12'h080;

   // Interrupt status bit positions.
   localparam int IRQ_POWER_MSG = 0;
   localparam int IRQ_CORR      = 1;
   localparam int IRQ_NONFATAL  = 2;
   localparam int IRQ_FATAL     = 3;
   localparam int IRQ_UNSUP     = 4;
   localparam int IRQ_WIDTH     = 5;

   // Power limit scale codes.
   typedef enum logic [1:0] {
      SCALE_1_0   = 2'h0,
      SCALE_0_1   = 2'h1,
      SCALE_0_01  = 2'h2,
      SCALE_0_001 = 2'h3
   } power_scale_type;

   // Slot power limit message content.
   typedef struct packed {
      logic            valid;
      logic [7:0]      value;
      power_scale_type scale;
   } power_msg_type;

   // Error detection pulses, one per class.
   typedef struct packed {
      logic unsupported;
      logic fatal;
      logic nonfatal;
      logic correctable;
   } error_event_type;

   // Register port request.
   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_type;

endpackage

/* File: verif/devctl_sva.sv */
// Purpose: Assertions on the ports of the device control register bank.
// Assumes: One clock domain with synchronous active-high reset.
// Notes:   Bound to every instance from the bench top file.
`timescale 1ns/10ps
module devctl_sva #(
   parameter bit UPSTREAM = 1'b1
) (
   input wire logic                        sys_clk_i,
   input wire logic                        rst_i,
   input wire devctl_pkg::reg_req_type     req_i,
   input wire devctl_pkg::power_msg_type   power_msg_i,
   input wire devctl_pkg::error_event_type error_i,
   input wire logic                        seq_tag_i,
   input wire logic                        tag_step_i,
   input wire logic [31:0]                 rdata_o,
   input wire logic                        irq_o,
   input wire logic [3:0]                  report_enable_o,
   input wire logic [3:0]                  error_message_o,
   input wire logic [11:0]                 max_payload_bytes_o,
   input wire logic [11:0]                 own_read_max_o,
   input wire logic                        own_relaxed_order_o,
   input wire logic                        own_no_snoop_o,
   input wire logic [7:0]                  next_tag_o
);
   // Every check uses the core clock and is silenced by reset.
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // Register port access steps.
   sequence s_ctl_wr; req_i.wr && req_i.addr == devctl_pkg::DEV_CTL_ADDR; endsequence
   sequence s_ctl_rd; req_i.rd && req_i.addr == devctl_pkg::DEV_CTL_ADDR; endsequence
   sequence s_cap_rd; req_i.rd && req_i.addr == devctl_pkg::DEV_CAP_ADDR; endsequence
   // Write effects, read-back values and fixed request attributes.
   property p_enables; s_ctl_wr |=> report_enable_o == $past(req_i.wdata[3:0]); endproperty
   a_enables: assert property (p_enables) else $error("enables differ");
   property p_payload; s_ctl_wr |=> max_payload_bytes_o == (($past(req_i.wdata[7:5]) > 3'h4)
      ? 12'h080 : (12'h080 << $past(req_i.wdata[7:5]))); endproperty
   a_payload: assert property (p_payload) else $error("payload wrong");
   property p_ctl_fixed; s_ctl_rd |=> (rdata_o[15:0] & ~devctl_pkg::CTL_WRITE_MASK) == 16'h0000;
   endproperty
   a_ctl_fixed: assert property (p_ctl_fixed) else $error("fixed bit set");
   property p_ctl_echo; s_ctl_rd |=> rdata_o[3:0] == $past(report_enable_o); endproperty
   a_ctl_echo: assert property (p_ctl_echo) else $error("enable readback");
   property p_cap; s_cap_rd |=> rdata_o[31:28] == 4'h0 && (UPSTREAM || rdata_o[27:18] == 10'h000);
   endproperty
   a_cap: assert property (p_cap) else $error("capture nonzero");
   property p_gate; 1 |=> error_message_o == ($past(error_i) & $past(report_enable_o)); endproperty
   a_gate: assert property (p_gate) else $error("message gating");
   property p_own; own_read_max_o == 12'h080 && !own_relaxed_order_o && !own_no_snoop_o;
   endproperty
   a_own: assert property (p_own) else $error("own attributes");
   property p_tag_idle; !seq_tag_i |=> next_tag_o == 8'h00; endproperty
   a_tag_idle: assert property (p_tag_idle) else $error("tag not idle");
endmodule

/* File: verif/tb.sv */
// Purpose: Self-checking bench for the device control register bank.
// Assumes: Upstream and downstream instances share every input.
// Notes:   Reads compare in the cycle after the strobe.
`timescale 1ns/10ps
module tb;
   localparam logic [11:0] CTL = devctl_pkg::DEV_CTL_ADDR;
   localparam logic [11:0] CAP = devctl_pkg::DEV_CAP_ADDR;
   logic sys_clk_i = 1'b0, rst_i = 1'b1, seq_i = 1'b0, step_i = 1'b0, irq_o;
   devctl_pkg::reg_req_type     req_i = '0;
   devctl_pkg::power_msg_type   pm_i  = '0;
   devctl_pkg::error_event_type err_i = '0;
   logic [31:0] rdata_o, rdata_dn;
   logic [11:0] mps_o;
   logic [7:0]  tag_o;
   logic [3:0]  msg_o;
   int fails = 0, checked = 0, cycles = 0;
   // Upstream bank under test and a downstream twin.
   device_control_regs #(.UPSTREAM(1'b1)) device_control_regs_i (.sys_clk_i(sys_clk_i),
      .rst_i(rst_i), .req_i(req_i), .power_msg_i(pm_i), .error_i(err_i), .seq_tag_i(seq_i),
      .tag_step_i(step_i), .rdata_o(rdata_o), .irq_o(irq_o), .report_enable_o(),
      .error_message_o(msg_o), .max_payload_bytes_o(mps_o), .own_read_max_o(),
      .own_relaxed_order_o(), .own_no_snoop_o(), .next_tag_o(tag_o));
   device_control_regs #(.UPSTREAM(1'b0)) device_control_regs_dn_i (.sys_clk_i(sys_clk_i),
      .rst_i(rst_i), .req_i(req_i), .power_msg_i(pm_i), .error_i(err_i), .seq_tag_i(seq_i),
      .tag_step_i(step_i), .rdata_o(rdata_dn), .irq_o(), .report_enable_o(),
      .error_message_o(), .max_payload_bytes_o(), .own_read_max_o(),
      .own_relaxed_order_o(), .own_no_snoop_o(), .next_tag_o());
   // Clock and hang guard.
   always #25 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fails++;
         conclude();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk_i);
      req_i.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge sys_clk_i);
      req_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk_i);
      req_i.rd <= 1'b0;
      #1 check(rdata_o, e);
   endtask
   task automatic conclude();
      if (fails == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Main sequence of register accesses and events.
   initial begin
      repeat (5) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rd(CTL, 32'h0);
      wr(CTL, 32'hFFFF_FFFF);
      rd(CTL, 32'h0000_01EF);
      for (int c = 0; c < 8; c++) begin
         wr(CTL, 32'(c) << 5);
         check(mps_o, (c > 4) ? 12'h080 : 12'h080 << c);
      end
      for (int s = 0; s < 4; s++) begin
         @(posedge sys_clk_i);
         pm_i <= '{valid: 1'b1, value: 8'hA5 ^ 8'(s), scale: devctl_pkg::power_scale_type'(s)};
         @(posedge sys_clk_i);
         pm_i.valid <= 1'b0;
         rd(CAP, {4'h0, 2'(s), 8'hA5 ^ 8'(s), 18'h0});
         check(rdata_dn, 32'h0);
      end
      wr(CTL, 32'h0000_0001);
      @(posedge sys_clk_i);
      err_i <= 4'hF;
      @(posedge sys_clk_i);
      err_i <= 4'h0;
      #1 check(msg_o, 32'h1);
      rd(devctl_pkg::DEV_STS_ADDR, 32'h0000_000F);
      check(irq_o, 1'b0);
      wr(devctl_pkg::IRQ_MASK_ADDR, 32'h0000_001F);
      @(posedge sys_clk_i);
      #1 check(irq_o, 1'b1);
      rd(devctl_pkg::IRQ_STATUS_ADDR, 32'h0000_001F);
      @(posedge sys_clk_i);
      #1 check(irq_o, 1'b0);
      rd(12'h0FC, 32'h0);
      wr(devctl_pkg::DEV_STS_ADDR, 32'h0000_000F);
      rd(devctl_pkg::DEV_STS_ADDR, 32'h0);
      wr(CTL, 32'h0);
      @(posedge sys_clk_i);
      seq_i <= 1'b1;
      step_i <= 1'b1;
      rd(devctl_pkg::DEBUG_CTL_ADDR, 32'h1);
      repeat (40) begin
         @(posedge sys_clk_i);
         #1 check(tag_o > 8'h1F, 1'b0);
      end
      wr(CTL, 32'h0000_0100);
      repeat (40) @(posedge sys_clk_i);
      #1 check(tag_o > 8'h1F, 1'b1);
      conclude();
   end
endmodule
bind device_control_regs devctl_sva #(.UPSTREAM(UPSTREAM)) devctl_sva_i (.sys_clk_i(sys_clk_i),
   .rst_i(rst_i), .req_i(req_i), .power_msg_i(power_msg_i), .error_i(error_i),
   .seq_tag_i(seq_tag_i), .tag_step_i(tag_step_i), .rdata_o(rdata_o), .irq_o(irq_o),
   .report_enable_o(report_enable_o), .error_message_o(error_message_o),
   .max_payload_bytes_o(max_payload_bytes_o), .own_read_max_o(own_read_max_o),
   .own_relaxed_order_o(own_relaxed_order_o), .own_no_snoop_o(own_no_snoop_o),
   .next_tag_o(next_tag_o));
